// ---- hdl/timer_capture_compare_unit.sv ----
`default_nettype none
module timer_capture_compare_unit
   import tcc_pkg::*;
(
   // clock and reset
   input  wire logic               i_sys_clk,
   input  wire logic               i_resetn,
   input  wire logic               i_count_tick,
   // mode control register access
   input  wire logic               i_mode_wr,
   input  wire logic [MODE_W-1:0]  i_mode_wdata,
   input  wire logic               i_mode_bit_wr,
   input  wire logic [BIT_SEL_W-1:0] i_mode_bit_sel,
   input  wire logic               i_mode_bit_val,
   // compare register writes
   input  wire logic               i_first_wr,
   input  wire logic [COUNT_W-1:0] i_first_wdata,
   input  wire logic               i_second_wr,
   input  wire logic [COUNT_W-1:0] i_second_wdata,
   // capture control and edge selects
   input  wire logic               i_first_capture_mode,
   input  wire logic               i_second_capture_mode,
   input  wire logic               i_capture_source_select,
   input  wire logic               i_first_input_edge_hi,
   input  wire logic               i_first_input_edge_lo,
   input  wire logic               i_second_input_edge_hi,
   input  wire logic               i_second_input_edge_lo,
   // trigger pins
   input  wire logic               i_first_ext_input,
   input  wire logic               i_second_ext_input,
   // state and interrupts
   output var  logic [MODE_W-1:0]  o_timer_mode_control,
   output var  logic [COUNT_W-1:0] o_count_value,
   output var  logic [COUNT_W-1:0] o_compare_capture_first,
   output var  logic [COUNT_W-1:0] o_compare_capture_second,
   output var  logic               o_first_match_irq,
   output var  logic               o_second_match_irq
);
   function automatic logic edge_valid(input logic [1:0] sel,
                                       input logic       rise,
                                       input logic       fall);
      case (sel)
         EDGE_RISE: edge_valid = rise;
         EDGE_FALL: edge_valid = fall;
         EDGE_BOTH: edge_valid = rise | fall;
         default:   edge_valid = 1'b0;
      endcase
   endfunction
   logic               first_rise;
   logic               first_fall;
   logic               second_rise;
   logic               second_fall;
   logic               cleared;
   logic               next_cleared;
   logic [MODE_W-1:0]  next_mode;
   logic [COUNT_W-1:0] next_count;
   logic [COUNT_W-1:0] next_first;
   logic [COUNT_W-1:0] next_second;
   tcc_pin_edge u_first_pin (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_first_ext_input),
      .o_rise    (first_rise),
      .o_fall    (first_fall)
   );
   tcc_pin_edge u_second_pin (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_second_ext_input),
      .o_rise    (second_rise),
      .o_fall    (second_fall)
   );
   wire [1:0] op = o_timer_mode_control[OP_HI_BIT:OP_LO_BIT];
   wire [1:0] es_first  = {i_first_input_edge_hi, i_first_input_edge_lo};
   wire [1:0] es_second = {i_second_input_edge_hi, i_second_input_edge_lo};
   wire running = (op != OP_STOP);
   wire first_edge  = edge_valid(es_first, first_rise, first_fall);
   wire second_edge = edge_valid(es_second, second_rise, second_fall);
   wire rev_edge = ((es_first == EDGE_RISE) & first_rise)
                 | ((es_first == EDGE_FALL) & first_fall);
   wire edge_clear  = running & (op == OP_EDGE_CLR) & first_edge;
   wire match_clear = running & (op == OP_MATCH_CLR) & i_count_tick
                    & ~i_first_capture_mode
                    & (o_count_value == o_compare_capture_first);
   wire wrap = running & i_count_tick & (o_count_value == COUNT_MAX);
   wire step = running & i_count_tick & ~edge_clear & ~match_clear;
   wire [COUNT_W-1:0] inc = o_count_value + COUNT_ONE;
   wire at_zero = (o_count_value == COUNT_ZERO);
   function automatic logic cmp_hit(input logic [15:0] cmp,
                                    input logic [15:0] nxt,
                                    input logic        zero,
                                    input logic        clr);
      // zero matches only stepping zero to one after a clear or a wrap
      cmp_hit = (cmp != COUNT_ZERO) ? (nxt == cmp) : (zero & clr);
   endfunction
   wire match_first  = step & ~i_first_capture_mode
                     & cmp_hit(o_compare_capture_first, inc, at_zero, cleared);
   wire match_second = step & ~i_second_capture_mode
                     & cmp_hit(o_compare_capture_second, inc, at_zero, cleared);
   // capture source for the first register
   wire cap_first = running & i_first_capture_mode
                  & (i_capture_source_select ? rev_edge : second_edge);
   wire cap_second = running & i_second_capture_mode & first_edge;
   wire irq_first  = match_first
                   | (running & i_first_capture_mode & second_edge);
   wire irq_second = match_second | cap_second;
   logic [MODE_W-1:0] wr_mode;
   always_comb begin
      wr_mode = o_timer_mode_control;
      if (i_mode_wr) begin
         wr_mode = i_mode_wdata;
      end
      if (i_mode_bit_wr) begin
         wr_mode[i_mode_bit_sel] = i_mode_bit_val;
      end
      // eight bits, upper nibble reads zero
      next_mode = wr_mode & MODE_USED;
      // overflow set wins over a clearing write
      if (wrap) begin
         next_mode[OVF_BIT] = 1'b1;
      end else if (wr_mode[OP_HI_BIT:OP_LO_BIT] == OP_STOP) begin
         next_mode[OVF_BIT] = 1'b0;
      end
   end
   always_comb begin
      next_count = o_count_value;
      next_cleared = cleared;
      if (!running) begin
         next_count = COUNT_ZERO;
         next_cleared = 1'b0;
      end else if (edge_clear | match_clear) begin
         next_count = COUNT_ZERO;
         next_cleared = 1'b1;
      end else if (i_count_tick) begin
         next_count = inc;
         next_cleared = cleared | wrap;
      end
   end
   // capture takes priority over a software write
   assign next_first  = cap_first ? o_count_value
                      : (i_first_wr ? i_first_wdata : o_compare_capture_first);
   assign next_second = cap_second ? o_count_value
                      : (i_second_wr ? i_second_wdata
                                     : o_compare_capture_second);
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_timer_mode_control     <= MODE_RESET;
         o_count_value            <= COUNT_ZERO;
         o_compare_capture_first  <= COUNT_ZERO;
         o_compare_capture_second <= COUNT_ZERO;
         o_first_match_irq        <= 1'b0;
         o_second_match_irq       <= 1'b0;
         cleared                  <= 1'b0;
      end else begin
         o_timer_mode_control     <= next_mode;
         o_count_value            <= next_count;
         o_compare_capture_first  <= next_first;
         o_compare_capture_second <= next_second;
         o_first_match_irq        <= irq_first;
         o_second_match_irq       <= irq_second;
         cleared                  <= next_cleared;
      end
   end
   property p_reserved_zero;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_timer_mode_control & ~MODE_USED) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("mode register reserved bits not zero");
   property p_reset_mode;
      @(posedge i_sys_clk) $rose(i_resetn) |-> o_timer_mode_control == MODE_RESET;
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("mode register not zero after reset");
   property p_stop_clears;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      !running |=> o_count_value == COUNT_ZERO;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("stopped counter not cleared");
   property p_count_steps;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      step |=> o_count_value == $past(o_count_value) + COUNT_ONE;
   endproperty
   a_count_steps: assert property (p_count_steps)
      else $error("running counter did not step");
   property p_byte_write;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_mode_wr & ~i_mode_bit_wr & ~wrap
       & (i_mode_wdata[OP_HI_BIT:OP_LO_BIT] != OP_STOP))
      |=> o_timer_mode_control == ($past(i_mode_wdata) & MODE_USED);
   endproperty
   a_byte_write: assert property (p_byte_write)
      else $error("byte write not stored");
   property p_nonzero_match;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (step & ~i_first_capture_mode & (inc == o_compare_capture_first)
       & (o_compare_capture_first != COUNT_ZERO)) |=> o_first_match_irq;
   endproperty
   a_nonzero_match: assert property (p_nonzero_match)
      else $error("first match interrupt missing");
   property p_zero_after_start;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      ($rose(running) & ~i_first_capture_mode
       & (o_compare_capture_first == COUNT_ZERO))
      |-> ##1 !o_first_match_irq;
   endproperty
   a_zero_after_start: assert property (p_zero_after_start)
      else $error("zero compare matched right after start");
   property p_zero_match;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (step & cleared & at_zero & ~i_first_capture_mode
       & (o_compare_capture_first == COUNT_ZERO))
      |=> o_first_match_irq && o_count_value == COUNT_ONE;
   endproperty
   a_zero_match: assert property (p_zero_match)
      else $error("zero compare missed step to one");
   property p_rev_capture;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (running & i_first_capture_mode & i_capture_source_select
       & rev_edge & ~second_edge)
      |=> o_compare_capture_first == $past(o_count_value)
          && !o_first_match_irq;
   endproperty
   a_rev_capture: assert property (p_rev_capture)
      else $error("reverse phase capture wrong");
   property p_both_no_cap;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_first_capture_mode & i_capture_source_select
       & (es_first == EDGE_BOTH) & ~i_first_wr)
      |=> $stable(o_compare_capture_first);
   endproperty
   a_both_no_cap: assert property (p_both_no_cap)
      else $error("both-edge setting captured");
   property p_src0_capture;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (running & i_first_capture_mode & ~i_capture_source_select
       & second_edge)
      |=> o_first_match_irq
          && o_compare_capture_first == $past(o_count_value);
   endproperty
   a_src0_capture: assert property (p_src0_capture)
      else $error("second-input capture into first wrong");
   property p_second_capture;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (running & i_second_capture_mode & first_edge)
      |=> o_second_match_irq
          && o_compare_capture_second == $past(o_count_value);
   endproperty
   a_second_capture: assert property (p_second_capture)
      else $error("second register capture wrong");
   property p_ext_irq;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (running & i_first_capture_mode & i_capture_source_select
       & second_edge & ~rev_edge & ~i_first_wr)
      |=> o_first_match_irq && $stable(o_compare_capture_first);
   endproperty
   a_ext_irq: assert property (p_ext_irq)
      else $error("external first interrupt wrong");
   c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
      wrap ##1 o_timer_mode_control[OVF_BIT]);
   c_match_clear: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) match_clear);
   c_rev_capture: cover property (@(posedge i_sys_clk)
      disable iff (!i_resetn) cap_first & i_capture_source_select);
endmodule
`default_nettype wire

// ---- pkg/tcc_pkg.sv ----
`default_nettype none
package tcc_pkg;
   // mode control register layout
   localparam int        MODE_W         = 8;
   localparam int        OP_HI_BIT      = 3;
   localparam int        OP_LO_BIT      = 2;
   localparam int        OUT_TIMING_BIT = 1;
   localparam int        OVF_BIT        = 0;
   localparam int        BIT_SEL_W      = 3;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] MODE_USED     = 8'h0F;
   // operation field encodings
   localparam logic [1:0] OP_STOP       = 2'h0;
   localparam logic [1:0] OP_FREE       = 2'h1;
   localparam logic [1:0] OP_EDGE_CLR   = 2'h2;
   localparam logic [1:0] OP_MATCH_CLR  = 2'h3;
   // edge field encodings
   localparam logic [1:0] EDGE_FALL     = 2'h0;
   localparam logic [1:0] EDGE_RISE     = 2'h1;
   localparam logic [1:0] EDGE_BOTH     = 2'h3;
   // counter
   localparam int         COUNT_W       = 16;
   localparam logic [15:0] COUNT_ZERO   = 16'h0000;
   localparam logic [15:0] COUNT_ONE    = 16'h0001;
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
endpackage
`default_nettype wire

// ---- hdl/tcc_pin_edge.sv ----
`default_nettype none
module tcc_pin_edge (
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   // pin and detected edges
   input  wire logic i_pin,
   output var  logic o_rise,
   output var  logic o_fall
);
   logic meta;
   logic stable;
   logic prev;

   // two flops before any logic looks at the pin
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else begin
         meta   <= i_pin;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign o_rise = stable & ~prev;
   assign o_fall = ~stable & prev;
endmodule
`default_nettype wire

// ---- tb/tcc_pin_model.sv ----
`default_nettype none
module tcc_pin_model (
   // clock and toggle requests
   input  wire logic i_sys_clk,
   input  wire logic i_tog_first,
   input  wire logic i_tog_second,
   // trigger pins
   output var  logic o_first_ext_input,
   output var  logic o_second_ext_input
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_first_ext_input  = 1'b0;
      o_second_ext_input = 1'b0;
   end
   // pins move off the clock grid, as a real source would
   always @(posedge i_sys_clk) begin
      if (i_tog_first) o_first_ext_input <= #2 ~o_first_ext_input;
      if (i_tog_second) o_second_ext_input <= #2 ~o_second_ext_input;
   end
endmodule
`default_nettype wire

// ---- tb/timer_capture_compare_unit_tb.sv ----
`default_nettype none
module timer_capture_compare_unit_tb
   import tcc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_sys_clk = 1'b0, i_resetn = 1'b0, i_count_tick = 1'b0;
   logic        i_mode_wr = 1'b0, i_mode_bit_wr = 1'b0, i_mode_bit_val = 1'b0;
   logic        i_first_wr = 1'b0, i_second_wr = 1'b0;
   logic [7:0]  i_mode_wdata = 8'h00;
   logic [2:0]  i_mode_bit_sel = 3'h0;
   logic [15:0] i_first_wdata = 16'h0000, i_second_wdata = 16'h0000;
   logic        i_first_capture_mode = 1'b0, i_second_capture_mode = 1'b0;
   logic        i_capture_source_select = 1'b0;
   logic        i_first_input_edge_hi = 1'b0, i_first_input_edge_lo = 1'b0;
   logic        i_second_input_edge_hi = 1'b0, i_second_input_edge_lo = 1'b0;
   logic        tog_first = 1'b0, tog_second = 1'b0;
   wire logic   i_first_ext_input, i_second_ext_input;
   logic [7:0]  o_timer_mode_control;
   logic [15:0] o_count_value, o_compare_capture_first;
   logic [15:0] o_compare_capture_second;
   logic        o_first_match_irq, o_second_match_irq;
   int          n_errors = 0, checked = 0;

   always #2.5 i_sys_clk = ~i_sys_clk;

   timer_capture_compare_unit u_timer_capture_compare_unit (
      .i_sys_clk, .i_resetn, .i_count_tick, .i_mode_wr, .i_mode_wdata,
      .i_mode_bit_wr, .i_mode_bit_sel, .i_mode_bit_val, .i_first_wr,
      .i_first_wdata, .i_second_wr, .i_second_wdata, .i_first_capture_mode,
      .i_second_capture_mode, .i_capture_source_select,
      .i_first_input_edge_hi, .i_first_input_edge_lo,
      .i_second_input_edge_hi, .i_second_input_edge_lo,
      .i_first_ext_input, .i_second_ext_input, .o_timer_mode_control,
      .o_count_value, .o_compare_capture_first, .o_compare_capture_second,
      .o_first_match_irq, .o_second_match_irq);

   tcc_pin_model u_tcc_pin_model (
      .i_sys_clk, .i_tog_first(tog_first), .i_tog_second(tog_second),
      .o_first_ext_input(i_first_ext_input),
      .o_second_ext_input(i_second_ext_input));

   task automatic step;
      @(posedge i_sys_clk);
      #1;
   endtask

   task automatic chk_val(input logic [15:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   // k: 0 mode byte, 1 mode bit, 2 first reg, 3 second reg
   task automatic wr(input int k, input logic [15:0] d, input logic [2:0] s);
      i_mode_wdata = d[7:0];
      i_mode_bit_sel = s;
      i_mode_bit_val = d[0];
      i_first_wdata = d;
      i_second_wdata = d;
      {i_mode_wr, i_mode_bit_wr, i_first_wr, i_second_wr} = 4'h8 >> k;
      step;
      {i_mode_wr, i_mode_bit_wr, i_first_wr, i_second_wr} = 4'h0;
      step;
   endtask

   function automatic logic exp_irq(input logic [15:0] v, e, input logic c);
      return (v != COUNT_ZERO) ? (e == v) : (c && e == COUNT_ONE);
   endfunction

   task automatic t_reset;
      chk_val({8'h00, o_timer_mode_control}, 16'h0000, "mode");
      chk_val(o_count_value, 16'h0000, "count");
      $display("test reset done");
   endtask

   task automatic t_mode;
      wr(0, 16'h00F2, 3'h0);
      chk_val({8'h00, o_timer_mode_control}, 16'h0002, "byte");
      wr(1, 16'h0000, 3'h1);
      chk_val({8'h00, o_timer_mode_control}, 16'h0000, "bit1");
      wr(1, 16'h0001, 3'h3);
      chk_val({8'h00, o_timer_mode_control}, 16'h0008, "bit3");
      wr(1, 16'h0000, 3'h0);
      chk_val({8'h00, o_timer_mode_control}, 16'h0008, "ovf");
      wr(0, 16'h0000, 3'h0);
      chk_val({8'h00, o_timer_mode_control}, 16'h0000, "stop");
      $display("test mode register done");
   endtask

   task automatic t_cmp(input logic [15:0] v1, v2, input logic [1:0] op,
                        input int n);
      logic [15:0] e;
      logic        c;
      e = COUNT_ZERO;
      c = 1'b0;
      {i_first_capture_mode, i_second_capture_mode} = 2'b00;
      wr(2, v1, 3'h0);
      wr(3, v2, 3'h0);
      wr(0, {12'h000, op, 2'h0}, 3'h0);
      i_count_tick = 1'b1;
      repeat (n) begin
         chk_val(o_count_value, e, "count");
         chk_bit(o_first_match_irq, exp_irq(v1, e, c), "irq1");
         chk_bit(o_second_match_irq, exp_irq(v2, e, c), "irq2");
         step;
         c = c | (op == OP_MATCH_CLR && e == v1);
         e = (op == OP_MATCH_CLR && e == v1) ? COUNT_ZERO : e + 16'h0001;
      end
      i_count_tick = 1'b0;
      wr(0, 16'h0000, 3'h0);
      chk_val(o_count_value, 16'h0000, "stopped");
      $display("test compare op %0d done", op);
   endtask

   task automatic t_edge_clr;
      {i_first_capture_mode, i_second_capture_mode} = 2'b00;
      {i_first_input_edge_hi, i_first_input_edge_lo} = EDGE_RISE;
      wr(2, 16'h0000, 3'h0);
      wr(0, 16'h0008, 3'h0);
      i_count_tick = 1'b1;
      repeat (5) step;
      i_count_tick = 1'b0;
      chk_val(o_count_value, 16'h0005, "run");
      tog_first = 1'b1;
      step;
      tog_first = 1'b0;
      repeat (8) step;
      chk_val(o_count_value, 16'h0000, "edge clear");
      i_count_tick = 1'b1;
      step;
      i_count_tick = 1'b0;
      chk_val(o_count_value, 16'h0001, "step after clear");
      chk_bit(o_first_match_irq, 1'b1, "zero match");
      tog_first = 1'b1;
      step;
      tog_first = 1'b0;
      wr(0, 16'h0000, 3'h0);
      $display("test edge clear done");
   endtask

   task automatic t_cap;
      logic [15:0] e1, e2, k;
      logic        rise, sec, v, rv;
      int          n1, n2;
      {i_first_capture_mode, i_second_capture_mode} = 2'b11;
      wr(2, 16'hAAAA, 3'h0);
      wr(3, 16'h5555, 3'h0);
      e1 = 16'hAAAA;
      e2 = 16'h5555;
      k = COUNT_ZERO;
      wr(0, 16'h0004, 3'h0);
      for (int s = 0; s < 2; s++) for (int f = 0; f < 4; f++) if (f != 2)
      for (int t = 0; t < 4; t++) begin
         i_capture_source_select = s[0];
         {i_first_input_edge_hi, i_first_input_edge_lo} = f[1:0];
         {i_second_input_edge_hi, i_second_input_edge_lo} = f[1:0];
         i_count_tick = 1'b1;
         step;
         i_count_tick = 1'b0;
         k = k + 16'h0001;
         sec = t[0];
         rise = !t[1];
         {tog_second, tog_first} = {sec, !sec};
         step;
         {tog_second, tog_first} = 2'b00;
         n1 = 0;
         n2 = 0;
         repeat (8) begin
            step;
            n1 += int'(o_first_match_irq);
            n2 += int'(o_second_match_irq);
         end
         v = f == 3 || (f == 1) == rise;
         rv = f != 3 && v;
         if (!sec && v) e2 = k;
         if (!sec && s == 1 && rv) e1 = k;
         if (sec && s == 0 && v) e1 = k;
         chk_val(16'(n1), {15'h0, sec && v}, "irq1 count");
         chk_val(16'(n2), {15'h0, !sec && v}, "irq2 count");
         chk_val(o_compare_capture_first, e1, "first");
         chk_val(o_compare_capture_second, e2, "second");
      end
      wr(0, 16'h0000, 3'h0);
      $display("test capture done");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      finish_test;
   end

   initial begin
      repeat (8) step;
      i_resetn = 1'b1;
      step;
      t_reset;
      t_mode;
      t_cmp(16'h0005, 16'h0007, OP_FREE, 10);
      t_cmp(16'h0003, 16'h0000, OP_MATCH_CLR, 14);
      t_cmp(16'h0006, 16'h0002, OP_MATCH_CLR, 16);
      t_edge_clr;
      t_cap;
      finish_test;
   end
endmodule
`default_nettype wire
